// *** verilog/twm_pkg.sv ***
/*
  twm_pkg: constants, types and helpers for the 16-bit timer waveform block.
  Assumes a single core clock domain and an APB register port with 12-bit
  byte addresses and 32-bit data.
*/
package twm_pkg;

  // ***************************************************************
  // register indices (byte address is four times the index)
  // ***************************************************************
  localparam logic [9:0]  IDX_CTRL_A    = 10'h080;
  localparam logic [9:0]  IDX_CTRL_B    = 10'h081;
  localparam logic [9:0]  IDX_COUNT     = 10'h090;
  localparam logic [9:0]  IDX_CMP_A     = 10'h091;
  localparam logic [9:0]  IDX_CMP_B     = 10'h092;
  localparam logic [9:0]  IDX_CAPTURE   = 10'h093;
  localparam logic [9:0]  IDX_INT_STAT  = 10'h094;
  localparam logic [9:0]  IDX_INT_MASK  = 10'h095;
  localparam logic [9:0]  IDX_TICK_CTRL = 10'h096;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int unsigned CA_ACT_A_HI  = 7;
  localparam int unsigned CA_ACT_A_LO  = 6;
  localparam int unsigned CA_ACT_B_HI  = 5;
  localparam int unsigned CA_ACT_B_LO  = 4;
  localparam int unsigned CA_MODE_HI   = 1;
  localparam int unsigned CA_MODE_LO   = 0;
  localparam int unsigned CB_MODE_HI   = 4;
  localparam int unsigned CB_MODE_LO   = 3;
  localparam int unsigned TC_RUN_BIT   = 16;
  localparam int unsigned INT_OVF      = 0;
  localparam int unsigned INT_CMP_A    = 1;
  localparam int unsigned INT_CMP_B    = 2;
  localparam logic [7:0]  CTRL_A_RST   = 8'h00;
  localparam logic [7:0]  CTRL_A_WMASK = 8'hf3;

  // ***************************************************************
  // counter limits
  // ***************************************************************
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_CTC    = 3'b001,
    WAVE_FAST   = 3'b010,
    WAVE_PC     = 3'b011,
    WAVE_PFC    = 3'b100,
    WAVE_RSVD   = 3'b101
  } twm_wave_t;

  typedef enum logic [1:0] {
    TOP_FIXED   = 2'b00,
    TOP_CMP_A   = 2'b01,
    TOP_CAPTURE = 2'b10
  } twm_top_src_t;

  typedef enum logic [1:0] {
    PT_IMMEDIATE = 2'b00,
    PT_TOP       = 2'b01,
    PT_BOTTOM    = 2'b10,
    PT_MAX       = 2'b11
  } twm_point_t;

  typedef struct packed {
    twm_wave_t    wave;
    twm_top_src_t top_src;
    logic [15:0]  fixed_top;
    twm_point_t   upd;
    twm_point_t   flag;
  } twm_mode_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } twm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } twm_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [1:0]  mode_hi;
    logic [15:0] cnt;
    logic        down;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_buf_b;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [2:0]  int_stat;
    logic [2:0]  int_mask;
    logic        tick_run;
    logic [15:0] tick_div;
    logic [15:0] div_cnt;
    logic        tick;
    logic        block;
    logic        oc_a;
    logic        oe_a;
    logic        oc_b;
    logic        oe_b;
    logic        irq;
    twm_apb_rsp_t rsp;
  } twm_state_t;

  localparam twm_state_t TWM_STATE_RST = '0;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic twm_hit(input logic [11:0] addr, input logic [9:0] idx);
    twm_hit = (addr == {idx, 2'b00});
  endfunction

endpackage

// *** verilog/twm_mode_decode.sv ***
/*
  twm_mode_decode: turns the four-bit waveform mode into counting sequence,
  TOP source, compare update point and overflow flag point.
  Assumes a stable mode from registers on the same clock; purely combinational.
*/
`timescale 1ns/1ps
module twm_mode_decode
  import twm_pkg::*;
(
  input  wire logic [3:0]    mode,
  output twm_mode_cfg_t      cfg
);

  // ***************************************************************
  // mode table
  // ***************************************************************
  always_comb begin
    cfg = '{WAVE_RSVD, TOP_FIXED, CNT_MAX, PT_IMMEDIATE, PT_MAX};
    unique case (mode)
      4'h0: cfg = '{WAVE_NORMAL, TOP_FIXED, CNT_MAX, PT_IMMEDIATE, PT_MAX};
      4'h1: cfg = '{WAVE_PC, TOP_FIXED, TOP_8BIT, PT_TOP, PT_BOTTOM};
      4'h2: cfg = '{WAVE_PC, TOP_FIXED, TOP_9BIT, PT_TOP, PT_BOTTOM};
      4'h3: cfg = '{WAVE_PC, TOP_FIXED, TOP_10BIT, PT_TOP, PT_BOTTOM};
      4'h4: cfg = '{WAVE_CTC, TOP_CMP_A, CNT_MAX, PT_IMMEDIATE, PT_MAX};
      4'h5: cfg = '{WAVE_FAST, TOP_FIXED, TOP_8BIT, PT_TOP, PT_TOP};
      4'h6: cfg = '{WAVE_FAST, TOP_FIXED, TOP_9BIT, PT_TOP, PT_TOP};
      4'h7: cfg = '{WAVE_FAST, TOP_FIXED, TOP_10BIT, PT_TOP, PT_TOP};
      4'h8: cfg = '{WAVE_PFC, TOP_CAPTURE, CNT_MAX, PT_BOTTOM, PT_BOTTOM};
      4'h9: cfg = '{WAVE_PFC, TOP_CMP_A, CNT_MAX, PT_BOTTOM, PT_BOTTOM};
      4'ha: cfg = '{WAVE_PC, TOP_CAPTURE, CNT_MAX, PT_TOP, PT_BOTTOM};
      4'hb: cfg = '{WAVE_PC, TOP_CMP_A, CNT_MAX, PT_TOP, PT_BOTTOM};
      4'hc: cfg = '{WAVE_CTC, TOP_CAPTURE, CNT_MAX, PT_IMMEDIATE, PT_MAX};
      // reserved code: counter frozen, pins released
      4'hd: cfg = '{WAVE_RSVD, TOP_FIXED, CNT_MAX, PT_IMMEDIATE, PT_MAX};
      4'he: cfg = '{WAVE_FAST, TOP_CAPTURE, CNT_MAX, PT_TOP, PT_TOP};
      4'hf: cfg = '{WAVE_FAST, TOP_CMP_A, CNT_MAX, PT_TOP, PT_TOP};
    endcase
  end

endmodule

// *** verilog/twm_timer16.sv ***
/*
  twm_timer16: 16-bit timer with waveform mode decode, compare double
  buffering, two compare output pins, overflow/compare flags and an APB port.
  Assumes port direction bits come from port logic on core_clk and an APB
  master on core_clk; reset is synchronous, active high.
*/
// Operation
// - synchronous counter, tick is a clock enable
// - frequency-correct modes reload compares at BOTTOM
// - nonzero action field takes over the pin
// - drive pin only when direction is output
// - non-PWM: off, toggle, clear, set on match
// - fast PWM 01: toggle A in 14/15
// - fast PWM: match and TOP act oppositely
// - fast PWM: compare at TOP ignores match
// - dual-slope 01: toggle A in 8..11 only
// - dual-slope: up match and down match opposite
// - control A bits 3:2 read zero
// - four-bit mode from both control registers
// - normal and clear-on-match TOP, update, flag
// - phase-correct TOP values, update TOP, flag BOTTOM
// - fast PWM TOP values, update and flag TOP
// - frequency-correct TOP source, update and flag BOTTOM
// - upper mode bits in control B 4:3
`timescale 1ns/1ps
module twm_timer16
  import twm_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire twm_apb_req_t  apb_req,
  output twm_apb_rsp_t       apb_rsp,
  input  wire logic          port_dir_a,
  input  wire logic          port_dir_b,
  output logic               compare_out_a_pin,
  output logic               compare_out_a_oe,
  output logic               compare_out_b_pin,
  output logic               compare_out_b_oe,
  output logic               timer_irq
);

  // ***************************************************************
  // waveform step for one channel
  // ***************************************************************
  // returns {connected, next level}; shared by both channels
  function automatic logic [1:0] wave_step(
    input logic      oc,
    input logic [1:0] act,
    input twm_wave_t wave,
    input logic [3:0] mode,
    input logic      chan_a,
    input logic      match,
    input logic      top_step,
    input logic      cmp_is_top,
    input logic      down
  );
    logic conn;
    logic lvl;
    conn = 1'b0;
    lvl  = oc;
    if (act != 2'b00) begin
      conn = 1'b1;
      unique case (wave)
        WAVE_NORMAL, WAVE_CTC: begin
          if (match) begin
            unique case (act)
              2'b01:   lvl = ~oc;
              2'b10:   lvl = 1'b0;
              default: lvl = 1'b1;
            endcase
          end
        end
        WAVE_FAST: begin
          if (act == 2'b01) begin
            conn = chan_a && (mode == 4'he || mode == 4'hf);
            if (conn && match) begin
              lvl = ~oc;
            end
          end else begin
            // compare at TOP would fight the TOP edge, so the TOP action wins
            if (match && !cmp_is_top) begin
              lvl = act[0];
            end
            if (top_step) begin
              lvl = ~act[0];
            end
          end
        end
        WAVE_PC, WAVE_PFC: begin
          if (act == 2'b01) begin
            conn = chan_a && (mode >= 4'h8) && (mode <= 4'hb);
            if (conn && match) begin
              lvl = ~oc;
            end
          end else if (match) begin
            lvl = down ? ~act[0] : act[0];
          end
        end
        default: begin
          conn = 1'b0;
        end
      endcase
    end
    wave_step = {conn, lvl};
  endfunction

  // ***************************************************************
  // state and mode decode
  // ***************************************************************
  twm_state_t    s;
  twm_state_t    n;
  twm_mode_cfg_t cfg;
  logic [3:0]    mode;

  assign mode = {s.mode_hi, s.ctrl_a[CA_MODE_HI:CA_MODE_LO]};

  twm_mode_decode u_decode (
    .mode (mode),
    .cfg  (cfg)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  logic [15:0] top;
  logic        dual;
  logic        step;
  logic        at_top;
  logic        at_bot;
  logic        at_max;
  logic        match_a;
  logic        match_b;
  logic        ovf_ev;
  logic        upd_ev;
  logic        setup;
  logic        commit;
  logic [2:0]  clr;
  logic [2:0]  set;
  logic [1:0]  res_a;
  logic [1:0]  res_b;
  logic [31:0] rd;
  logic        hit;

  always_comb begin
    n = s;
    top = CNT_MAX;
    if (cfg.top_src == TOP_FIXED) begin
      top = cfg.fixed_top;
    end else if (cfg.top_src == TOP_CMP_A) begin
      top = s.cmp_a;
    end else begin
      top = s.cap;
    end
    dual   = (cfg.wave == WAVE_PC) || (cfg.wave == WAVE_PFC);
    at_top = (s.cnt == top);
    at_bot = (s.cnt == CNT_BOTTOM);
    at_max = (s.cnt == CNT_MAX);

    // tick divider: one-cycle enable, never a derived clock
    n.tick = 1'b0;
    if (!s.tick_run) begin
      n.div_cnt = 16'h0000;
    end else if (s.div_cnt >= s.tick_div) begin
      n.div_cnt = 16'h0000;
      n.tick    = 1'b1;
    end else begin
      n.div_cnt = s.div_cnt + 16'h0001;
    end
    step = s.tick && (cfg.wave != WAVE_RSVD);

    // counting sequence
    if (step) begin
      n.block = 1'b0;
      if (dual) begin
        if (!s.down) begin
          // a TOP of zero (compare not loaded yet) must not turn below BOTTOM
          if (s.cnt >= top && !at_bot) begin
            n.down = 1'b1;
            n.cnt  = s.cnt - 16'h0001;
          end else begin
            n.cnt = s.cnt + 16'h0001;
          end
        end else if (at_bot) begin
          n.down = 1'b0;
          n.cnt  = s.cnt + 16'h0001;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end else begin
        n.down = 1'b0;
        n.cnt  = at_top ? CNT_BOTTOM : s.cnt + 16'h0001;
      end
    end

    // a counter write suppresses the match on the next tick
    match_a = step && !s.block && (s.cnt == s.cmp_a);
    match_b = step && !s.block && (s.cnt == s.cmp_b);

    unique case (cfg.flag)
      PT_MAX:    ovf_ev = step && at_max;
      PT_TOP:    ovf_ev = step && at_top;
      PT_BOTTOM: ovf_ev = step && at_bot;
      default:   ovf_ev = 1'b0;
    endcase

    unique case (cfg.upd)
      PT_IMMEDIATE: upd_ev = 1'b1;
      PT_TOP:       upd_ev = step && at_top;
      PT_BOTTOM:    upd_ev = step && at_bot;
      default:      upd_ev = 1'b0;
    endcase
    if (upd_ev) begin
      n.cmp_a = s.cmp_buf_a;
      n.cmp_b = s.cmp_buf_b;
    end

    // compare outputs
    res_a = wave_step(s.oc_a, s.ctrl_a[CA_ACT_A_HI:CA_ACT_A_LO], cfg.wave, mode, 1'b1,
                      match_a, step && at_top, s.cmp_a == top, s.down);
    res_b = wave_step(s.oc_b, s.ctrl_a[CA_ACT_B_HI:CA_ACT_B_LO], cfg.wave, mode, 1'b0,
                      match_b, step && at_top, s.cmp_b == top, s.down);
    n.oc_a = res_a[0];
    n.oc_b = res_b[0];
    n.oe_a = res_a[1] && port_dir_a;
    n.oe_b = res_b[1] && port_dir_b;

    // apb: zero-wait slave, response prepared in the setup cycle
    setup  = apb_req.psel && !apb_req.penable;
    commit = apb_req.psel && apb_req.penable && s.rsp.pready;
    hit    = 1'b1;
    rd     = 32'h0000_0000;
    if (twm_hit(apb_req.paddr, IDX_CTRL_A)) begin
      rd[7:0] = s.ctrl_a & CTRL_A_WMASK;
    end else if (twm_hit(apb_req.paddr, IDX_CTRL_B)) begin
      rd[CB_MODE_HI:CB_MODE_LO] = s.mode_hi;
    end else if (twm_hit(apb_req.paddr, IDX_COUNT)) begin
      rd[15:0] = s.cnt;
    end else if (twm_hit(apb_req.paddr, IDX_CMP_A)) begin
      rd[15:0] = s.cmp_buf_a;
    end else if (twm_hit(apb_req.paddr, IDX_CMP_B)) begin
      rd[15:0] = s.cmp_buf_b;
    end else if (twm_hit(apb_req.paddr, IDX_CAPTURE)) begin
      rd[15:0] = s.cap;
    end else if (twm_hit(apb_req.paddr, IDX_INT_STAT)) begin
      rd[2:0] = s.int_stat;
    end else if (twm_hit(apb_req.paddr, IDX_INT_MASK)) begin
      rd[2:0] = s.int_mask;
    end else if (twm_hit(apb_req.paddr, IDX_TICK_CTRL)) begin
      rd[TC_RUN_BIT] = s.tick_run;
      rd[15:0]       = s.tick_div;
    end else begin
      hit = 1'b0;
    end
    n.rsp.pready = setup;
    if (setup) begin
      n.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
      n.rsp.pslverr = !hit;
    end else begin
      n.rsp.pslverr = 1'b0;
    end

    clr = 3'b000;
    if (commit && apb_req.pwrite && hit) begin
      if (twm_hit(apb_req.paddr, IDX_CTRL_A)) begin
        n.ctrl_a = apb_req.pwdata[7:0] & CTRL_A_WMASK;
      end else if (twm_hit(apb_req.paddr, IDX_CTRL_B)) begin
        n.mode_hi = apb_req.pwdata[CB_MODE_HI:CB_MODE_LO];
      end else if (twm_hit(apb_req.paddr, IDX_COUNT)) begin
        n.cnt   = apb_req.pwdata[15:0];
        n.block = 1'b1;
      end else if (twm_hit(apb_req.paddr, IDX_CMP_A)) begin
        n.cmp_buf_a = apb_req.pwdata[15:0];
      end else if (twm_hit(apb_req.paddr, IDX_CMP_B)) begin
        n.cmp_buf_b = apb_req.pwdata[15:0];
      end else if (twm_hit(apb_req.paddr, IDX_CAPTURE)) begin
        n.cap = apb_req.pwdata[15:0];
      end else if (twm_hit(apb_req.paddr, IDX_INT_STAT)) begin
        clr = apb_req.pwdata[2:0];
      end else if (twm_hit(apb_req.paddr, IDX_INT_MASK)) begin
        n.int_mask = apb_req.pwdata[2:0];
      end else begin
        n.tick_run = apb_req.pwdata[TC_RUN_BIT];
        n.tick_div = apb_req.pwdata[15:0];
      end
    end

    // sticky flags: a new event beats a write-one-to-clear in the same cycle
    set            = 3'b000;
    set[INT_OVF]   = ovf_ev;
    set[INT_CMP_A] = match_a;
    set[INT_CMP_B] = match_b;
    n.int_stat     = (s.int_stat & ~clr) | set;
    n.irq          = |(n.int_stat & n.int_mask);
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= TWM_STATE_RST;
    end else begin
      s <= n;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign apb_rsp           = s.rsp;
  assign compare_out_a_pin = s.oc_a;
  assign compare_out_a_oe  = s.oe_a;
  assign compare_out_b_pin = s.oc_b;
  assign compare_out_b_oe  = s.oe_b;
  assign timer_irq         = s.irq;

endmodule

// *** verification/twm_timer16_chk.sv ***
/*
  twm_timer16_chk: port-level assertions for twm_timer16.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module twm_timer16_chk
  import twm_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         reset,
  input wire twm_apb_req_t apb_req,
  input wire twm_apb_rsp_t apb_rsp,
  input wire logic         port_dir_a,
  input wire logic         port_dir_b,
  input wire logic         compare_out_a_pin,
  input wire logic         compare_out_a_oe,
  input wire logic         compare_out_b_pin,
  input wire logic         compare_out_b_oe,
  input wire logic         timer_irq
);
  // ********
  // shadow of action and mode fields
  // ********
  logic [7:0] ca_r;
  logic [1:0] mh_r;
  logic [3:0] md;
  logic       wr;
  logic       pwm;
  logic       off_a;
  logic       off_b;

  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ca_r <= 8'h00;
      mh_r <= 2'h0;
    end else if (wr && apb_req.paddr == {IDX_CTRL_A, 2'h0}) begin
      ca_r <= apb_req.pwdata[7:0];
    end else if (wr && apb_req.paddr == {IDX_CTRL_B, 2'h0}) begin
      mh_r <= apb_req.pwdata[4:3];
    end
  end
  // normal and clear-on-match are the only non-PWM modes
  assign md    = {mh_r, ca_r[1:0]};
  assign pwm   = !(md inside {4'h0, 4'h4, 4'hc});
  assign off_a = (ca_r[7:6] == 2'h0) || (md == 4'hd) ||
                 (ca_r[7:6] == 2'h1 && pwm && !(md inside {[4'h8:4'hb], 4'he, 4'hf}));
  assign off_b = (ca_r[5:4] == 2'h0) || (md == 4'hd) || (ca_r[5:4] == 2'h1 && pwm);

  // ********
  // assertions
  // ********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_PREADY_NEXT: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  AST_PREADY_CAUSE: assert property (apb_rsp.pready |-> $past(apb_req.psel) &&
    !$past(apb_req.penable)) else $error("ready without setup");
  AST_ERR_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  AST_CTRLA_RSVD: assert property (
    apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == {IDX_CTRL_A, 2'h0}
    |-> apb_rsp.prdata[3:2] == 2'h0 && apb_rsp.prdata[31:8] == 24'h0)
    else $error("control a reserved bits set");
  AST_OE_DIR_A: assert property (compare_out_a_oe |-> $past(port_dir_a))
    else $error("pin a driven while input");
  AST_OE_DIR_B: assert property (compare_out_b_oe |-> $past(port_dir_b))
    else $error("pin b driven while input");
  AST_OFF_A: assert property (off_a && $past(off_a) |-> !compare_out_a_oe)
    else $error("pin a driven while disconnected");
  AST_OFF_B: assert property (off_b && $past(off_b) |-> !compare_out_b_oe)
    else $error("pin b driven while disconnected");
  AST_ON_A: assert property (
    !off_a && !$past(off_a) && $past(port_dir_a) |-> compare_out_a_oe)
    else $error("pin a not taken over");
  AST_ON_B: assert property (
    !off_b && !$past(off_b) && $past(port_dir_b) |-> compare_out_b_oe)
    else $error("pin b not taken over");
  AST_RST_QUIET: assert property ($past(reset) |-> !timer_irq && !compare_out_a_oe &&
    !compare_out_b_oe && !apb_rsp.pready) else $error("outputs active after reset");
endmodule

// *** verification/twm_port_model.sv ***
/*
  twm_port_model: port pads and direction bits behind the compare outputs.
  Assumes the bench sets the direction bits on core_clk.
*/
`timescale 1ns/1ps
module twm_port_model (
  input  wire logic dir_a_set,
  input  wire logic dir_b_set,
  input  wire logic pin_a,
  input  wire logic oe_a,
  input  wire logic pin_b,
  input  wire logic oe_b,
  output logic      port_dir_a,
  output logic      port_dir_b,
  output logic      pad_a,
  output logic      pad_b
);
  assign port_dir_a = dir_a_set;
  assign port_dir_b = dir_b_set;
  // a released pad goes to the pull-up, never keeps the last driven level
  assign pad_a = oe_a ? pin_a : 1'b1;
  assign pad_b = oe_b ? pin_b : 1'b1;
endmodule

// *** verification/twm_timer16_tb_top.sv ***
/*
  twm_timer16_tb_top: self-checking bench for twm_timer16.
  Assumes the checker and the port model are compiled before it.
*/
`timescale 1ns/1ps
module twm_timer16_tb_top
  import twm_pkg::*;
;
  logic         core_clk;
  logic         reset;
  twm_apb_req_t req;
  twm_apb_rsp_t rsp;
  logic         dir_a;
  logic         dir_b;
  logic         pdir_a;
  logic         pdir_b;
  logic         pin_a;
  logic         oe_a;
  logic         pin_b;
  logic         oe_b;
  logic         irq;
  logic         pad_a;
  logic         pad_b;
  logic [31:0]  rd;
  logic         err;
  int           ha;
  int           hb;
  int           n_fail;
  int           comparisons;
  int           tm[6] = '{32'h5, 32'h6, 32'h7, 32'h1, 32'h2, 32'h3};
  int           tw[6] = '{32'h100, 32'h200, 32'h400, 32'h1fe, 32'h3fe, 32'h7fe};

  twm_timer16 i_twm_timer16 (.core_clk(core_clk), .reset(reset), .apb_req(req),
    .apb_rsp(rsp), .port_dir_a(pdir_a), .port_dir_b(pdir_b), .compare_out_a_pin(pin_a),
    .compare_out_a_oe(oe_a), .compare_out_b_pin(pin_b), .compare_out_b_oe(oe_b),
    .timer_irq(irq));
  twm_port_model i_twm_port_model (.dir_a_set(dir_a), .dir_b_set(dir_b), .pin_a(pin_a),
    .oe_a(oe_a), .pin_b(pin_b), .oe_b(oe_b), .port_dir_a(pdir_a), .port_dir_b(pdir_b),
    .pad_a(pad_a), .pad_b(pad_b));

  // ********
  // bench tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // requests change just after an edge and hold until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask

  task automatic wreg(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'h0}, d);
  endtask

  task automatic rreg(input logic [9:0] i);
    apb(1'b0, {i, 2'h0}, 32'h0);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
  endtask

  // one waveform: settle a full window, then count pad high cycles over another
  task automatic run(input logic [3:0] m, input logic [3:0] act, input logic [15:0] ca,
                     input logic [15:0] cb, input logic [15:0] cap, input int w,
                     input int ea, input int eb);
    do_reset();
    wreg(IDX_CTRL_B, {27'h0, m[3:2], 3'h0});
    wreg(IDX_CTRL_A, {24'h0, act, 2'h0, m[1:0]});
    wreg(IDX_CMP_A, {16'h0, ca});
    wreg(IDX_CMP_B, {16'h0, cb});
    wreg(IDX_CAPTURE, {16'h0, cap});
    wreg(IDX_TICK_CTRL, 32'h0001_0000);
    repeat (w) @(posedge core_clk);
    ha = 0;
    hb = 0;
    repeat (w) begin
      @(posedge core_clk);
      ha += pad_a;
      hb += pad_b;
    end
    check("pad a high count", ha, ea);
    check("pad b high count", hb, eb);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_regs();
    do_reset();
    rreg(IDX_CTRL_A);
    check("ctrl a reset", rd, 32'h0);
    wreg(IDX_CTRL_A, 32'hffff_ffff);
    rreg(IDX_CTRL_A);
    check("ctrl a readback", rd, 32'hf3);
    wreg(IDX_CTRL_B, 32'hff);
    rreg(IDX_CTRL_B);
    check("ctrl b mode bits", rd, 32'h18);
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("registers done");
  endtask

  task automatic t_irq();
    do_reset();
    wreg(IDX_COUNT, 32'hfff0);
    wreg(IDX_TICK_CTRL, 32'h0001_0000);
    repeat (32'h1e) @(posedge core_clk);
    check("irq while masked", irq, 1'b0);
    rreg(IDX_INT_STAT);
    check("overflow at max", rd[0], 1'b1);
    wreg(IDX_INT_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq unmasked", irq, 1'b1);
    wreg(IDX_TICK_CTRL, 32'h0);
    wreg(IDX_INT_STAT, 32'h7);
    repeat (2) @(posedge core_clk);
    check("irq cleared", irq, 1'b0);
    rreg(IDX_INT_STAT);
    check("status cleared", rd, 32'h0);
    $display("interrupt done");
  endtask

  task automatic t_nonpwm();
    run(4'h0, 4'he, 16'h3, 16'h3, 16'h0, 32'h78, 32'h78, 32'h0);
    run(4'h4, 4'h7, 16'he, 16'h5, 16'h0, 32'h78, 32'h3c, 32'h78);
    run(4'hc, 4'h9, 16'h3, 16'h3, 16'he, 32'h78, 32'h0, 32'h3c);
    $display("non-pwm done");
  endtask

  task automatic t_fast();
    run(4'he, 4'hb, 16'h3, 16'h3, 16'he, 32'h78, 32'h20, 32'h58);
    run(4'he, 4'hb, 16'he, 16'he, 16'he, 32'h78, 32'h78, 32'h0);
    run(4'hf, 4'h5, 16'he, 16'h3, 16'h0, 32'h78, 32'h3c, 32'h78);
    run(4'h5, 4'h5, 16'h3, 16'h3, 16'h0, 32'h78, 32'h78, 32'h78);
    $display("fast pwm done");
  endtask

  task automatic t_fixed();
    for (int i = 0; i < 6; i++) begin
      run(tm[i][3:0], 4'hb, (tm[i] < 4) ? 16'h20 : 16'h3f, (tm[i] < 4) ? 16'h20 : 16'h3f,
          16'h0, tw[i], 32'h40, tw[i] - 32'h40);
    end
    $display("fixed top done");
  endtask

  task automatic t_dual();
    run(4'ha, 4'hb, 16'h4, 16'h4, 16'hf, 32'h78, 32'h20, 32'h58);
    run(4'h8, 4'hb, 16'h4, 16'h4, 16'hf, 32'h78, 32'h20, 32'h58);
    run(4'hb, 4'h5, 16'hf, 16'h4, 16'h0, 32'h78, 32'h3c, 32'h78);
    run(4'h9, 4'h5, 16'hf, 16'h4, 16'h0, 32'h78, 32'h3c, 32'h78);
    run(4'hd, 4'hb, 16'h4, 16'h4, 16'hf, 32'h78, 32'h78, 32'h78);
    $display("dual slope done");
  endtask

  task automatic t_dir();
    dir_b <= 1'b0;
    run(4'he, 4'hb, 16'h3, 16'h3, 16'he, 32'h78, 32'h20, 32'h78);
    check("pin b enable", oe_b, 1'b0);
    dir_b <= 1'b1;
    $display("direction done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    req = '0;
    dir_a = 1'b1;
    dir_b = 1'b1;
    n_fail = 0;
    comparisons = 0;
    t_regs();
    t_irq();
    t_nonpwm();
    t_fast();
    t_fixed();
    t_dual();
    t_dir();
    end_of_test();
  end
endmodule

bind twm_timer16 twm_timer16_chk i_twm_timer16_chk (.core_clk(core_clk), .reset(reset),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .port_dir_a(port_dir_a), .port_dir_b(port_dir_b),
  .compare_out_a_pin(compare_out_a_pin), .compare_out_a_oe(compare_out_a_oe),
  .compare_out_b_pin(compare_out_b_pin), .compare_out_b_oe(compare_out_b_oe),
  .timer_irq(timer_irq));
